// ===== bus_host.sv
// Purpose: Two-wire bus host model driving the sensor port's pins.
// Assumes: Open-drain lines with pull-ups; wire level fed back on scl/sda.
// Notes: Each step is 3 CLK cycles (SCL high 3, low 6); stretch waits are bounded.
`timescale 1ns/1ns
module bus_host (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_rel,
  output logic sda_rel,
  output logic hang
);
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    hang = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk) #1;
  endtask
  // One bus clock; waits while the device holds SCL low
  task automatic clk_bit(input logic b, output logic s);
    int n;
    sda_rel = b;
    tick(3);
    scl_rel = 1'b1;
    n = 0;
    while (scl !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    if (n == 2000) hang = 1'b1;
    tick(3);
    s = sda;
    scl_rel = 1'b0;
    tick(3);
  endtask
  // Also serves as repeated start when SCL is low
  task automatic start();
    sda_rel = 1'b1;
    tick(3);
    scl_rel = 1'b1;
    tick(3);
    sda_rel = 1'b0;
    tick(3);
    scl_rel = 1'b0;
    tick(3);
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    tick(3);
    scl_rel = 1'b1;
    tick(3);
    sda_rel = 1'b1;
    tick(3);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic rd(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(~ack, s);
  endtask
endmodule

// ===== humidity_temp_sensor_i2c_port_test.sv
// Purpose: Self-checking bench for the sensor two-wire port.
// Assumes: Shortened conversion and restart counts via parameters.
// Notes: Samples keep low bits zero so any resolution returns them whole.
`timescale 1ns/1ns
module humidity_temp_sensor_i2c_port_test;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic [13:0] TEMP_SAMPLE = 14'h1a40;
  logic [13:0] HUM_SAMPLE = 14'h1f40;
  logic SUPPLY_LOW = 1'b0;
  logic SCL_OE_N, SDA_OE_N, HEATER_ON, CONVERTING;
  logic scl_rel, sda_rel, hang;
  int error_cnt = 0;
  int n_checks = 0;
  wire scl_w = scl_rel & SCL_OE_N;
  wire sda_w = sda_rel & SDA_OE_N;
  always #4 CLK = ~CLK;
  sensor_port #(.TIME_DIV(10000), .SRST_CYCLES(24'h000032)) uut (
    .CLK(CLK), .RESET(RESET), .SCL_I(scl_w), .SCL_O(),
    .SCL_OE_N(SCL_OE_N), .SDA_I(sda_w), .SDA_O(), .SDA_OE_N(SDA_OE_N),
    .TEMP_SAMPLE(TEMP_SAMPLE), .HUM_SAMPLE(HUM_SAMPLE),
    .SUPPLY_LOW(SUPPLY_LOW), .HEATER_ON(HEATER_ON),
    .CONVERTING(CONVERTING));
  bus_host h (.clk(CLK), .scl(scl_w), .sda(sda_w), .scl_rel(scl_rel),
    .sda_rel(sda_rel), .hang(hang));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  task automatic reg_rd(output logic [7:0] d);
    logic a;
    h.start();
    h.wr(8'h80, a);
    h.wr(8'he7, a);
    h.start();
    h.wr(8'h81, a);
    h.rd(1'b0, d);
    h.stop();
  endtask
  task automatic reg_wr(input logic [7:0] d);
    logic a;
    h.start();
    h.wr(8'h80, a);
    h.wr(8'he6, a);
    h.wr(d, a);
    h.stop();
  endtask
  task automatic t_regs();
    logic [7:0] d;
    reg_rd(d);
    check(d, 8'h02);
    check(HEATER_ON, 1'b0);
    reg_wr((d & 8'h38) | 8'h86);
    reg_rd(d);
    check(d, 8'h86);
    check(HEATER_ON, 1'b1);
    $display("test regs done");
  endtask
  task automatic t_hold();
    logic a;
    int n;
    logic [7:0] hi, lo;
    h.start();
    h.wr(8'h80, a);
    h.wr(8'he3, a);
    h.start();
    h.wr(8'h81, a);
    check(a, 1'b1);
    check({CONVERTING, SCL_OE_N}, 2'b10);
    h.rd(1'b1, hi);
    h.rd(1'b0, lo);
    h.stop();
    n = 0;
    for (int i = 0; i < 20; i++) begin
      if (SDA_OE_N !== 1'b1) n++;
      h.tick(1);
    end
    check(n, 0);
    check({hi, lo} & 16'hfffc, {TEMP_SAMPLE, 2'b00});
    check(lo[1:0], 2'b00);
    $display("test hold done");
  endtask
  task automatic t_poll();
    logic a;
    int n;
    logic [7:0] hi, lo, c;
    reg_wr(8'h04);
    SUPPLY_LOW = 1'b1;
    h.start();
    h.wr(8'h80, a);
    h.wr(8'hf5, a);
    h.stop();
    n = 0;
    for (int i = 0; i < 50; i++) begin
      h.start();
      h.wr(8'h81, a);
      if (a) break;
      h.stop();
      n++;
    end
    check(a, 1'b1);
    check(n > 0, 1'b1);
    h.rd(1'b1, hi);
    h.rd(1'b1, lo);
    h.rd(1'b0, c);
    h.stop();
    check({hi, lo} & 16'hfffc, {HUM_SAMPLE, 2'b00});
    check(lo[1:0], 2'b10);
    check(c, crc8({hi, lo}));
    SUPPLY_LOW = 1'b0;
    reg_rd(c);
    check(c, 8'h46);
    $display("test poll done");
  endtask
  task automatic t_restart();
    logic a, b;
    logic [7:0] d;
    h.start();
    h.wr(8'h90, a);
    h.stop();
    check(a, 1'b0);
    h.start();
    h.wr(8'h80, a);
    h.wr(8'hfe, b);
    h.stop();
    check({a, b}, 2'b11);
    for (int i = 0; i < 200 && CONVERTING !== 1'b0; i++) h.tick(1);
    check(CONVERTING, 1'b0);
    reg_rd(d);
    check(d, 8'h02);
    check(HEATER_ON, 1'b0);
    $display("test restart done");
  endtask
  always @(posedge hang) begin
    error_cnt++;
    $display("MISMATCH t=%0t bus clock held too long", $time);
    end_sim();
  end
  initial begin
    repeat (3) @(posedge CLK);
    #1 RESET = 1'b0;
    h.tick(3);
    t_regs();
    t_hold();
    t_poll();
    t_restart();
    end_sim();
  end
endmodule

// ===== result_crc.sv
// Purpose: Checksum over the two result bytes, MSB first.
// Assumes: Purely combinational, one word per call.
// Notes:   Initial value zero, no final inversion.
`timescale 1ns/1ns
`include "sensor_map.svh"
module result_crc #(
  parameter int W = 16
) (
  input wire logic [W-1:0] data,
  output logic [7:0] crc
);
  always_comb begin
    logic [7:0] c;
    logic fb;
    c = `CRC_INIT;
    fb = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      fb = c[7] ^ data[i];
      c = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ `CRC_POLY;
      end
    end
    crc = c;
  end
endmodule

// ===== sensor_map.svh
// Purpose: Constants for the sensor two-wire port: address, commands,
//          settings layout, conversion and restart times.
// Assumes: 125 MHz system clock.
// Notes:   Times are in microseconds; counts derive from CLK_MHZ.
`ifndef SENSOR_MAP_SVH
`define SENSOR_MAP_SVH
`define DEV_ADDR 7'h40
`define CMD_T_HOLD 8'he3
`define CMD_H_HOLD 8'he5
`define CMD_T_POLL 8'hf3
`define CMD_H_POLL 8'hf5
`define CMD_SET_WR 8'he6
`define CMD_SET_RD 8'he7
`define CMD_SRESET 8'hfe
`define SET_RESET 8'h02
`define SET_WMASK 8'hbf
`define SET_KEEP 8'h44
`define BIT_RES_HI 7
`define BIT_LOWV 6
`define BIT_HEATER 2
`define BIT_NORELOAD 1
`define BIT_RES_LO 0
`define CRC_POLY 8'h31
`define CRC_INIT 8'h00
`define CLK_MHZ 125
`define SRST_US 15000
`define T14_US 50000
`define T13_US 25000
`define T12_US 13000
`define T11_US 7000
`define H12_US 16000
`define H11_US 8000
`define H10_US 5000
`define H8_US 3000
`endif

// ===== sensor_pkg.sv
// Purpose: Types shared by the sensor two-wire port.
// Assumes: Nothing beyond the map header.
// Notes:   Enums carry no explicit codes.
package sensor_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_RX, S_ACK, S_TX, S_TXACK, S_TXLD, S_HOLD
  } state_t;
  typedef enum logic [1:0] {R_HDR, R_CMD, R_DATA} role_t;
  typedef enum logic [1:0] {P_NONE, P_MEAS, P_REG} pend_t;
endpackage

// ===== sensor_port.sv
// Purpose: Two-wire target port of a humidity and temperature sensor:
//          measurement commands, settings register, soft restart.
// Assumes: SCL and SDA are sampled synchronously to CLK; open-drain pins
//          are driven low when the _OE_N output is low.
// Notes:   Conversion results come from the sample inputs at completion.
`timescale 1ns/1ns
`include "sensor_map.svh"
// Notes on behaviour
// - Polled read header during conversion is left unacknowledged.
// - Host not-acknowledge after second result byte suppresses the checksum.
// - Repeated start between command write and read header is accepted.
// - Soft restart reloads default settings and completes within 15 ms.
// - Soft restart is address write, command 0xfe, stop; both acknowledged.
// - Settings bit 6 reads 1 if supply was below 2.25 V when the last measurement completed.
// - Supply-low bit refreshes once after each completed measurement.
// - Writing 1 to the heater bit switches the on-chip heater on.
// - With reload enabled, each measurement command reloads defaults but heater and supply-low bits.
// - Settings bits 7 and 0 select measurement resolution.
// - Settings read via 0xe7 and read header; write via 0xe6 and data.
// - Results are two bytes MSB first, host acknowledges, then checksum.
// - Low byte bit 1 shows humidity (1) or temperature (0); bit 0 zero.
// - Clock-holding commands stretch SCL low until the result is ready.
module sensor_port #(
  parameter int unsigned TIME_DIV = 1,
  parameter logic [23:0] SRST_CYCLES = 24'(`SRST_US * `CLK_MHZ)
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE_N,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  input wire logic [13:0] TEMP_SAMPLE,
  input wire logic [13:0] HUM_SAMPLE,
  input wire logic SUPPLY_LOW,
  output logic HEATER_ON,
  output logic CONVERTING
);
  import sensor_pkg::*;

  state_t st_q, st_d;
  role_t role_q, role_d;
  pend_t pend_q, pend_d;
  logic [7:0] sh_q, sh_d, set_q, set_d, txb, crc;
  logic [3:0] bitc_q, bitc_d;
  logic [1:0] nb_q, nb_d, tx_sel, last_nb;
  logic [23:0] cnt_q, cnt_d;
  logic [15:0] res_q, res_d;
  logic scl_q, sda_q, sda_rel_q, sda_rel_d, rd_q, rd_d, more_q, more_d;
  logic hold_q, hold_d, hum_q, hum_d, busy_q, busy_d;
  logic srst_q, srst_d, srst_busy_q, srst_busy_d;
  logic scl_rise, scl_fall, start_c, stop_c, meas_done, srst_go, wr_commit;

  // Longest conversion time for the chosen type and resolution
  function automatic logic [23:0] conv_cycles(input logic [1:0] res,
                                              input logic hum);
    int unsigned us;
    us = 0;
    case ({hum, res})
      3'b000: us = `T14_US;
      3'b001: us = `T12_US;
      3'b010: us = `T13_US;
      3'b011: us = `T11_US;
      3'b100: us = `H12_US;
      3'b101: us = `H8_US;
      3'b110: us = `H10_US;
      default: us = `H11_US;
    endcase
    return 24'(us * `CLK_MHZ / TIME_DIV);
  endfunction

  assign scl_rise = SCL_I & ~scl_q;
  assign scl_fall = ~SCL_I & scl_q;
  assign start_c = scl_q & SCL_I & sda_q & ~SDA_I;
  assign stop_c = scl_q & SCL_I & ~sda_q & SDA_I;
  assign meas_done = busy_q && cnt_q == 24'h1 && !srst_busy_q;
  assign srst_go = stop_c && srst_q;
  assign wr_commit = st_q == S_RX && role_q == R_DATA && bitc_q == 4'h8
                     && scl_fall && !start_c && !stop_c;

  assign SCL_O = 1'b0;
  assign SCL_OE_N = ~(st_q == S_HOLD);
  assign SDA_O = 1'b0;
  assign SDA_OE_N = sda_rel_q;
  assign HEATER_ON = set_q[`BIT_HEATER];
  assign CONVERTING = busy_q;

  result_crc #(.W(16)) u_crc (
    .data(res_q),
    .crc(crc)
  );

  // Byte to send: first result or settings byte, second byte, checksum
  assign tx_sel = (st_q == S_TXLD) ? nb_q : 2'h0;
  assign last_nb = (pend_q == P_REG) ? 2'h0 : 2'h2;
  always_comb begin
    case (tx_sel)
      2'h0: txb = (pend_q == P_REG) ? set_q : res_q[15:8];
      2'h1: txb = res_q[7:0];
      default: txb = crc;
    endcase
  end

  always_comb begin
    logic ok;
    logic more;
    ok = 1'b0;
    more = 1'b0;
    st_d = st_q;
    role_d = role_q;
    pend_d = pend_q;
    sh_d = sh_q;
    set_d = set_q;
    bitc_d = bitc_q;
    nb_d = nb_q;
    cnt_d = cnt_q;
    res_d = res_q;
    sda_rel_d = sda_rel_q;
    rd_d = rd_q;
    more_d = more_q;
    hold_d = hold_q;
    hum_d = hum_q;
    busy_d = busy_q;
    srst_d = srst_q;
    srst_busy_d = srst_busy_q;
    if (busy_q) begin
      cnt_d = cnt_q - 24'h1;
      if (cnt_q == 24'h1) begin
        busy_d = 1'b0;
        srst_busy_d = 1'b0;
        if (!srst_busy_q) begin
          res_d = {hum_q ? HUM_SAMPLE : TEMP_SAMPLE, hum_q, 1'b0};
          set_d[`BIT_LOWV] = SUPPLY_LOW;
        end
      end
    end
    if (start_c) begin
      st_d = S_RX;
      role_d = R_HDR;
      bitc_d = 4'h0;
      sda_rel_d = 1'b1;
    end else if (stop_c) begin
      st_d = S_IDLE;
      sda_rel_d = 1'b1;
      if (srst_q) begin
        srst_d = 1'b0;
        set_d = `SET_RESET;
        pend_d = P_NONE;
        busy_d = 1'b1;
        srst_busy_d = 1'b1;
        cnt_d = SRST_CYCLES;
      end
    end else begin
      case (st_q)
        S_RX: begin
          if (scl_rise && bitc_q != 4'h8) begin
            sh_d = {sh_q[6:0], SDA_I};
            bitc_d = bitc_q + 4'h1;
          end
          if (scl_fall && bitc_q == 4'h8) begin
            case (role_q)
              R_HDR: begin
                rd_d = sh_q[0];
                more = ~sh_q[0];
                role_d = R_CMD;
                ok = sh_q[7:1] == `DEV_ADDR && !srst_busy_q
                     && (!sh_q[0] || pend_q == P_REG
                     || (pend_q == P_MEAS && (!busy_q || hold_q)));
              end
              R_CMD: begin
                ok = 1'b1;
                case (sh_q)
                  `CMD_T_HOLD, `CMD_H_HOLD, `CMD_T_POLL, `CMD_H_POLL: begin
                    pend_d = P_MEAS;
                    hold_d = sh_q == `CMD_T_HOLD || sh_q == `CMD_H_HOLD;
                    hum_d = sh_q == `CMD_H_HOLD || sh_q == `CMD_H_POLL;
                    if (!set_q[`BIT_NORELOAD]) begin
                      set_d = (`SET_RESET & ~`SET_KEEP)
                              | (set_d & `SET_KEEP);
                    end
                    busy_d = 1'b1;
                    srst_busy_d = 1'b0;
                    cnt_d = conv_cycles({set_d[`BIT_RES_HI],
                                         set_d[`BIT_RES_LO]}, hum_d);
                  end
                  `CMD_SET_RD: pend_d = P_REG;
                  `CMD_SET_WR: begin
                    more = 1'b1;
                    role_d = R_DATA;
                  end
                  `CMD_SRESET: srst_d = 1'b1;
                  default: ok = 1'b0;
                endcase
              end
              default: begin
                ok = 1'b1;
                set_d = (sh_q & `SET_WMASK) | (set_d & ~`SET_WMASK);
              end
            endcase
            more_d = more;
            sda_rel_d = ~ok;
            st_d = ok ? S_ACK : S_IDLE;
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            sda_rel_d = 1'b1;
            bitc_d = 4'h0;
            nb_d = 2'h0;
            if (!rd_q) begin
              st_d = more_q ? S_RX : S_IDLE;
            end else if (pend_q == P_MEAS && busy_q) begin
              st_d = S_HOLD;
            end else begin
              sh_d = txb;
              sda_rel_d = txb[7];
              st_d = S_TX;
            end
          end
        end
        S_HOLD: begin
          if (!busy_q) begin
            sh_d = txb;
            sda_rel_d = txb[7];
            bitc_d = 4'h0;
            st_d = S_TX;
          end
        end
        S_TX: begin
          if (scl_fall) begin
            bitc_d = bitc_q + 4'h1;
            if (bitc_q == 4'h7) begin
              sda_rel_d = 1'b1;
              st_d = S_TXACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              sda_rel_d = sh_q[6];
            end
          end
        end
        S_TXACK: begin
          if (scl_rise) begin
            if (!SDA_I && nb_q != last_nb) begin
              nb_d = nb_q + 2'h1;
              st_d = S_TXLD;
            end else begin
              st_d = S_IDLE;
            end
          end
        end
        S_TXLD: begin
          if (scl_fall) begin
            sh_d = txb;
            sda_rel_d = txb[7];
            bitc_d = 4'h0;
            st_d = S_TX;
          end
        end
        default: st_d = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_q <= S_IDLE;
      role_q <= R_HDR;
      pend_q <= P_NONE;
      sh_q <= 8'h00;
      set_q <= `SET_RESET;
      bitc_q <= 4'h0;
      nb_q <= 2'h0;
      cnt_q <= 24'h000000;
      res_q <= 16'h0000;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_rel_q <= 1'b1;
      rd_q <= 1'b0;
      more_q <= 1'b0;
      hold_q <= 1'b0;
      hum_q <= 1'b0;
      busy_q <= 1'b0;
      srst_q <= 1'b0;
      srst_busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      role_q <= role_d;
      pend_q <= pend_d;
      sh_q <= sh_d;
      set_q <= set_d;
      bitc_q <= bitc_d;
      nb_q <= nb_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      scl_q <= SCL_I;
      sda_q <= SDA_I;
      sda_rel_q <= sda_rel_d;
      rd_q <= rd_d;
      more_q <= more_d;
      hold_q <= hold_d;
      hum_q <= hum_d;
      busy_q <= busy_d;
      srst_q <= srst_d;
      srst_busy_q <= srst_busy_d;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  sequence s_hdr_done;
    st_q == S_RX && role_q == R_HDR && bitc_q == 4'h8 && scl_fall
    && !start_c && !stop_c;
  endsequence

  a_poll_busy_nack: assert property (
    (s_hdr_done ##0 (sh_q[0] && pend_q == P_MEAS && busy_q && !hold_q))
    |=> sda_rel_q && st_q == S_IDLE)
    else $error("polled read during conversion was acknowledged");
  a_foreign_addr: assert property (
    (s_hdr_done ##0 (sh_q[7:1] != `DEV_ADDR)) |=> sda_rel_q ##1 sda_rel_q)
    else $error("foreign address acknowledged");
  a_rstart_taken: assert property (
    start_c |=> st_q == S_RX && role_q == R_HDR && bitc_q == 4'h0)
    else $error("repeated start not taken");
  a_skip_checksum: assert property (
    (st_q == S_TXACK && scl_rise && SDA_I && !start_c && !stop_c)
    |=> st_q == S_IDLE && sda_rel_q)
    else $error("transmission continued after host nack");
  a_hold_scl: assert property (
    (st_q == S_HOLD && busy_q && !start_c && !stop_c)
    |=> !SCL_OE_N && sda_rel_q)
    else $error("clock not held during conversion");
  a_srst_defaults: assert property (
    srst_go |=> set_q == `SET_RESET && busy_q && cnt_q <= SRST_CYCLES)
    else $error("soft restart did not reload defaults");
  // Soft restart also clears the supply-low bit back to its default
  a_supply_refresh: assert property (
    $changed(set_q[`BIT_LOWV]) |-> $past(meas_done || srst_go))
    else $error("supply-low bit changed outside measurement end");
  a_status_bits: assert property (
    meas_done |=> res_q[1] == $past(hum_q) && !res_q[0])
    else $error("result status bits wrong");
  a_heater_write: assert property (
    (wr_commit && sh_q[`BIT_HEATER]) |=> HEATER_ON)
    else $error("heater not enabled by write");
endmodule
